// File: rtl/fma_pkg.sv
// Purpose: Shared constants and types for the frame metadata appender.
// Assumes: 32-bit register port, 32-bit payload words.
// Notes: Block type codes are also the selector values seen by software.
package fma_pkg;
  // Register offsets (byte addresses, one aligned word each).
  localparam logic [7:0] FMA_REG_ACTIVATE = 8'h00;
  localparam logic [7:0] FMA_REG_TYPE_SELECT = 8'h04;
  localparam logic [7:0] FMA_REG_TYPE_INCLUDE = 8'h08;
  localparam logic [7:0] FMA_REG_GAIN_SELECT = 8'h0C;
  localparam logic [7:0] FMA_REG_BLACK_SELECT = 8'h10;
  localparam logic [7:0] FMA_REG_STATUS = 8'h14;
  localparam logic [7:0] FMA_REG_LAST_CHECKSUM = 8'h18;
  localparam logic [7:0] FMA_REG_SERIAL_COUNT = 8'h1C;
  // Number of selectable block types.
  localparam int FMA_NUM_TYPES = 18;
  // Block type codes, in selector order.
  localparam logic [4:0] FMA_T_IMAGE = 5'h00;
  localparam logic [4:0] FMA_T_CHECKSUM = 5'h01;
  localparam logic [4:0] FMA_T_FRAME_ID = 5'h02;
  localparam logic [4:0] FMA_T_OFFSET_X = 5'h03;
  localparam logic [4:0] FMA_T_OFFSET_Y = 5'h04;
  localparam logic [4:0] FMA_T_WIDTH = 5'h05;
  localparam logic [4:0] FMA_T_HEIGHT = 5'h06;
  localparam logic [4:0] FMA_T_EXPOSURE = 5'h07;
  localparam logic [4:0] FMA_T_GAIN = 5'h08;
  localparam logic [4:0] FMA_T_BLACK = 5'h09;
  localparam logic [4:0] FMA_T_PIXFMT = 5'h0A;
  localparam logic [4:0] FMA_T_TIMESTAMP = 5'h0B;
  localparam logic [4:0] FMA_T_SEQ_INDEX = 5'h0C;
  localparam logic [4:0] FMA_T_SERIAL = 5'h0D;
  localparam logic [4:0] FMA_T_LINES = 5'h0E;
  localparam logic [4:0] FMA_T_COMP_MODE = 5'h0F;
  localparam logic [4:0] FMA_T_COMP_RATIO = 5'h10;
  localparam logic [4:0] FMA_T_DATARATE = 5'h11;
  // Include mask after reset: image and checksum only.
  localparam logic [17:0] FMA_INCLUDE_RESET = 18'h00003;
  localparam logic [17:0] FMA_ALWAYS_ON = 18'h00003;
  // Serial capture buffer depth in bytes.
  localparam int FMA_SERIAL_DEPTH = 16;
  localparam logic [4:0] FMA_SERIAL_DEPTH_W = 5'h10;
  // Checksum seed and polynomial (CRC-32, reflected form not used).
  localparam logic [31:0] FMA_CRC_SEED = 32'hFFFFFFFF;
  localparam logic [31:0] FMA_CRC_POLY = 32'h04C11DB7;
  // Block header marker in the top byte of a header word.
  localparam logic [7:0] FMA_HDR_MARK = 8'hC5;
  // Emitter states.
  typedef enum logic [2:0] {FMA_IDLE, FMA_PASS, FMA_HDR, FMA_BODY, FMA_END} fma_state_t;
endpackage

// File: rtl/fma_crc32.sv
// Purpose: Running 32-bit checksum over payload words.
// Assumes: One word per enabled cycle, clear before each frame.
// Notes: Bitwise serial form unrolled by a loop; fine at 250 MHz for 32 bits.
`timescale 1ns/1ns
module fma_crc32
  import fma_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic clear,
  input wire logic enable,
  input wire logic [31:0] data,
  output logic [31:0] crc
);
  logic [31:0] crc_q; // Current checksum.
  logic [31:0] crc_d; // Checksum after this word.

  // Fold each data bit into the register, most significant bit first.
  always_comb
  begin
    crc_d = crc_q;
    for (int i = 31; i >= 0; i--)
    begin
      if (crc_d[31] ^ data[i])
      begin
        crc_d = {crc_d[30:0], 1'b0} ^ FMA_CRC_POLY;
      end
      else
      begin
        crc_d = {crc_d[30:0], 1'b0};
      end
    end
  end

  // Seed on clear, accumulate on enable.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      crc_q <= FMA_CRC_SEED;
    end
    else if (clear)
    begin
      crc_q <= FMA_CRC_SEED;
    end
    else if (enable)
    begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule

// File: rtl/fma_sync2.sv
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Levels change slowly relative to CLK.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ns
module fma_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // First stage, may go metastable.
  logic [WIDTH-1:0] sync_q; // Second stage, safe to use.

  // Two stages in series.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// File: rtl/fma_top.sv
// Purpose: Frame metadata appender; passes image words and appends typed blocks.
// Assumes: Image words arrive with valid/ready; frame context is steady over a frame.
// Notes: Each block is a header word (mark, type, body length minus one) then its body words.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module fma_top
  import fma_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic ACQ_RUNNING,
  input wire logic [31:0] IMG_DATA,
  input wire logic IMG_VALID,
  input wire logic IMG_LAST,
  output logic IMG_READY,
  output logic [31:0] OUT_DATA,
  output logic OUT_VALID,
  output logic OUT_LAST,
  input wire logic OUT_READY,
  input wire logic [31:0] FRAME_ID,
  input wire logic [15:0] OFFSET_X,
  input wire logic [15:0] OFFSET_Y,
  input wire logic [15:0] WIDTH,
  input wire logic [15:0] HEIGHT,
  input wire logic [31:0] EXPOSURE,
  input wire logic [127:0] GAIN_ALL,
  input wire logic [31:0] BLACK_LEVEL,
  input wire logic [7:0] PIXEL_FORMAT,
  input wire logic [63:0] TIMESTAMP,
  input wire logic [7:0] SEQ_INDEX,
  input wire logic EXPOSURE_END,
  input wire logic [3:0] LINES,
  input wire logic COMPRESSED,
  input wire logic [31:0] COMP_RATIO,
  input wire logic [31:0] BITRATE,
  input wire logic [7:0] SER_DATA,
  input wire logic SER_VALID
);
  // Software settings.
  logic activate_q; // Global metadata activate.
  logic [4:0] type_sel_q; // Block type selector.
  logic [17:0] include_q; // Per-type include enables.
  logic [1:0] gain_sel_q; // Gain component chosen for the gain block.
  logic black_sel_q; // Black level component; only one exists.
  logic wr_ok; // Writes to selection allowed only when stopped.
  // Frame-side state.
  fma_state_t state_q; // Emitter state.
  logic [4:0] blk_q; // Block type being emitted.
  logic [1:0] word_q; // Body word index within block.
  logic [17:0] pend_q; // Blocks still to emit this frame.
  logic [3:0] lines_sync; // Synchronised I/O line levels.
  logic [3:0] lines_q; // Levels captured at exposure end.
  logic [31:0] crc_val; // Running checksum.
  logic [31:0] crc_last_q; // Checksum of the last frame that closed with a checksum block.
  logic crc_clr; // Seed checksum at frame start.
  logic img_xfer; // Image word accepted.
  // Serial capture.
  logic [7:0] ser_mem_q [FMA_SERIAL_DEPTH]; // Bytes for the next frame.
  logic [4:0] ser_cnt_q; // Bytes held.
  logic [4:0] ser_sent_q; // Count reported in the last frame.
  logic ser_ovf_q; // Capture overflowed.
  logic ser_drain; // Serial block finished, clear the buffer.
  // Block body helpers.
  logic [1:0] blk_len; // Body words minus one of current block.
  logic [31:0] body_word; // Current body word.
  logic [4:0] next_blk; // Lowest pending optional block.
  logic any_pend; // Some optional block is still pending.
  logic out_xfer; // Output word accepted.

  // Pin-side line levels cross into CLK before any use.
  fma_sync2 #(.WIDTH(4)) u_lines (
    .CLK(CLK),
    .RST_B(RST_B),
    .async_in(LINES),
    .sync_out(lines_sync)
  );

  // Checksum over the image words only.
  fma_crc32 u_crc (
    .CLK(CLK),
    .RST_B(RST_B),
    .clear(crc_clr),
    .enable(img_xfer),
    .data(IMG_DATA),
    .crc(crc_val)
  );

  assign wr_ok = WR && !ACQ_RUNNING;
  assign img_xfer = (state_q == FMA_PASS) && IMG_VALID && OUT_READY;
  assign out_xfer = OUT_VALID && OUT_READY;
  assign crc_clr = (state_q == FMA_IDLE);

  // Activate register; frozen while acquisition runs.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      activate_q <= 1'b0;
    end
    else if (wr_ok && ADDR == FMA_REG_ACTIVATE)
    begin
      activate_q <= WDATA[0];
    end
  end

  // Selector; values beyond the last type are ignored.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      type_sel_q <= FMA_T_IMAGE;
    end
    else if (wr_ok && ADDR == FMA_REG_TYPE_SELECT && WDATA[4:0] <= FMA_T_DATARATE)
    begin
      type_sel_q <= WDATA[4:0];
    end
  end

  // Include enables act on the selected type; image and checksum stay set.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      include_q <= FMA_INCLUDE_RESET;
    end
    else if (wr_ok && ADDR == FMA_REG_TYPE_INCLUDE)
    begin
      include_q[type_sel_q] <= WDATA[0] | FMA_ALWAYS_ON[type_sel_q];
    end
  end

  // Component selectors for gain and black level.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      gain_sel_q <= 2'h0;
      black_sel_q <= 1'b0;
    end
    else if (wr_ok && ADDR == FMA_REG_GAIN_SELECT)
    begin
      gain_sel_q <= WDATA[1:0];
    end
    else if (wr_ok && ADDR == FMA_REG_BLACK_SELECT)
    begin
      black_sel_q <= 1'b0; // Only the "all" component exists.
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      RDATA <= 32'h00000000;
    end
    else if (RD)
    begin
      case (ADDR)
        FMA_REG_ACTIVATE: RDATA <= {31'h0, activate_q};
        FMA_REG_TYPE_SELECT: RDATA <= {27'h0, type_sel_q};
        FMA_REG_TYPE_INCLUDE: RDATA <= {31'h0, include_q[type_sel_q]};
        FMA_REG_GAIN_SELECT: RDATA <= {30'h0, gain_sel_q};
        FMA_REG_BLACK_SELECT: RDATA <= {31'h0, black_sel_q};
        FMA_REG_STATUS: RDATA <= {28'h0, lines_q[0], ser_ovf_q, ACQ_RUNNING, activate_q};
        FMA_REG_LAST_CHECKSUM: RDATA <= crc_last_q;
        FMA_REG_SERIAL_COUNT: RDATA <= {27'h0, ser_sent_q};
        default: RDATA <= 32'h00000000;
      endcase
    end
    else
    begin
      RDATA <= 32'h00000000;
    end
  end

  // Line levels are all sampled together on the exposure end event.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      lines_q <= 4'h0;
    end
    else if (EXPOSURE_END)
    begin
      lines_q <= lines_sync;
    end
  end

  // Serial capture: store bytes until full, then flag overflow.
  // Bytes arriving during the drain cycle are dropped; a rare loss traded for simplicity.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ser_cnt_q <= 5'h00;
      ser_ovf_q <= 1'b0;
      ser_sent_q <= 5'h00;
    end
    else if (ser_drain)
    begin
      ser_sent_q <= ser_cnt_q;
      ser_cnt_q <= 5'h00;
      ser_ovf_q <= SER_VALID; // Set wins over the clear.
    end
    else if (SER_VALID)
    begin
      if (ser_cnt_q == FMA_SERIAL_DEPTH_W)
      begin
        ser_ovf_q <= 1'b1;
      end
      else
      begin
        ser_cnt_q <= ser_cnt_q + 5'h01;
      end
    end
  end

  // Serial byte storage.
  always_ff @(posedge CLK)
  begin
    if (SER_VALID && !ser_drain && ser_cnt_q != FMA_SERIAL_DEPTH_W)
    begin
      ser_mem_q[ser_cnt_q[3:0]] <= SER_DATA;
    end
  end

  assign ser_drain = out_xfer && state_q == FMA_BODY && blk_q == FMA_T_SERIAL
    && word_q == blk_len;

  // Lowest pending optional block type, checksum last.
  always_comb
  begin
    next_blk = FMA_T_CHECKSUM;
    any_pend = 1'b0;
    for (int i = FMA_NUM_TYPES - 1; i >= 2; i--)
    begin
      if (pend_q[i])
      begin
        next_blk = 5'(i);
        any_pend = 1'b1;
      end
    end
  end

  // Body length minus one and body word per block type.
  always_comb
  begin
    blk_len = 2'h0;
    body_word = 32'h00000000;
    case (blk_q)
      FMA_T_CHECKSUM: body_word = crc_val;
      FMA_T_FRAME_ID: body_word = FRAME_ID;
      FMA_T_OFFSET_X: body_word = {16'h0, OFFSET_X};
      FMA_T_OFFSET_Y: body_word = {16'h0, OFFSET_Y};
      FMA_T_WIDTH: body_word = {16'h0, WIDTH};
      FMA_T_HEIGHT: body_word = {16'h0, HEIGHT};
      FMA_T_EXPOSURE: body_word = EXPOSURE;
      FMA_T_GAIN: body_word = GAIN_ALL[gain_sel_q*32 +: 32];
      FMA_T_BLACK: body_word = BLACK_LEVEL;
      FMA_T_PIXFMT: body_word = {24'h0, PIXEL_FORMAT};
      FMA_T_TIMESTAMP:
      begin
        blk_len = 2'h1;
        body_word = word_q[0] ? TIMESTAMP[63:32] : TIMESTAMP[31:0];
      end
      FMA_T_SEQ_INDEX: body_word = {24'h0, SEQ_INDEX};
      FMA_T_SERIAL:
      begin
        // Word 0 is the count, words 1..3 carry up to twelve bytes.
        blk_len = 2'h3;
        if (word_q == 2'h0)
        begin
          body_word = {26'h0, ser_ovf_q, ser_cnt_q};
        end
        else
        begin
          body_word = {ser_mem_q[{word_q - 2'h1, 2'h3}], ser_mem_q[{word_q - 2'h1, 2'h2}],
            ser_mem_q[{word_q - 2'h1, 2'h1}], ser_mem_q[{word_q - 2'h1, 2'h0}]};
        end
      end
      FMA_T_LINES: body_word = {28'h0, lines_q};
      FMA_T_COMP_MODE: body_word = {31'h0, COMPRESSED};
      FMA_T_COMP_RATIO: body_word = COMPRESSED ? COMP_RATIO : 32'h00000000;
      FMA_T_DATARATE: body_word = COMPRESSED ? BITRATE : 32'h00000000;
      default: body_word = 32'h00000000;
    endcase
  end

  // Emitter: image words, then pending blocks, checksum block closes the frame.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_q <= FMA_IDLE;
      blk_q <= FMA_T_IMAGE;
      word_q <= 2'h0;
      pend_q <= 18'h00000;
      crc_last_q <= 32'h00000000;
    end
    else
    begin
      case (state_q)
        FMA_IDLE:
        begin
          if (IMG_VALID)
          begin
            state_q <= FMA_PASS;
            pend_q <= activate_q ? include_q : 18'h00000;
          end
        end
        FMA_PASS:
        begin
          if (img_xfer && IMG_LAST)
          begin
            // Without activate the frame ends with its last image word.
            state_q <= activate_q ? FMA_HDR : FMA_IDLE;
            blk_q <= next_blk;
            word_q <= 2'h0;
          end
        end
        FMA_HDR:
        begin
          if (out_xfer)
          begin
            state_q <= FMA_BODY;
          end
        end
        FMA_BODY:
        begin
          if (out_xfer)
          begin
            if (word_q != blk_len)
            begin
              word_q <= word_q + 2'h1;
            end
            else if (blk_q == FMA_T_CHECKSUM)
            begin
              state_q <= FMA_IDLE;
              crc_last_q <= crc_val;
            end
            else
            begin
              pend_q[blk_q] <= 1'b0;
              state_q <= FMA_END;
            end
          end
        end
        FMA_END:
        begin
          // One idle cycle lets the pending mask settle before the next pick.
          state_q <= FMA_HDR;
          blk_q <= any_pend ? next_blk : FMA_T_CHECKSUM;
          word_q <= 2'h0;
        end
        default: state_q <= FMA_IDLE;
      endcase
    end
  end

  // Output path; image words pass straight through under back-pressure.
  always_comb
  begin
    IMG_READY = (state_q == FMA_PASS) && OUT_READY;
    OUT_VALID = 1'b0;
    OUT_DATA = 32'h00000000;
    OUT_LAST = 1'b0;
    case (state_q)
      FMA_PASS:
      begin
        OUT_VALID = IMG_VALID;
        OUT_DATA = IMG_DATA;
        OUT_LAST = IMG_LAST && !activate_q;
      end
      FMA_HDR:
      begin
        OUT_VALID = 1'b1;
        OUT_DATA = {FMA_HDR_MARK, 3'h0, blk_q, 14'h0, blk_len};
      end
      FMA_BODY:
      begin
        OUT_VALID = 1'b1;
        OUT_DATA = body_word;
        OUT_LAST = (blk_q == FMA_T_CHECKSUM);
      end
      default: OUT_VALID = 1'b0;
    endcase
  end
endmodule

// File: verification/fma_monitor.sv
// Purpose: Port checker for the frame metadata appender.
// Assumes: Activate is written only between frames.
// Notes: act_q follows activate so stream checks know the mode.
`timescale 1ns/1ns
module fma_monitor
  import fma_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic ACQ_RUNNING,
  input wire logic [31:0] IMG_DATA,
  input wire logic IMG_VALID,
  input wire logic IMG_LAST,
  input wire logic IMG_READY,
  input wire logic [31:0] OUT_DATA,
  input wire logic OUT_VALID,
  input wire logic OUT_LAST,
  input wire logic OUT_READY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic act_q; // Activate as last written outside acquisition.
  // Writes during acquisition are skipped, as the device must skip them.
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
      act_q <= 1'b0;
    else if (WR && !ACQ_RUNNING && ADDR == FMA_REG_ACTIVATE)
      act_q <= WDATA[0];
  sequence s_rd_act;
    RD && ADDR == FMA_REG_ACTIVATE;
  endsequence
  sequence s_run_wr_act;
    ACQ_RUNNING && WR && ADDR == FMA_REG_ACTIVATE;
  endsequence
  sequence s_crc_hdr;
    OUT_VALID && OUT_READY && OUT_DATA == {FMA_HDR_MARK, 3'h0, FMA_T_CHECKSUM, 16'h0000};
  endsequence
  // Read, refused write, read again: both reads must agree.
  property p_frozen;
    logic v;
    s_rd_act ##1 (1'b1, v = RDATA[0]) ##1 s_run_wr_act ##2 s_rd_act |=> RDATA[0] == v;
  endproperty
  AST_RD_IDLE_ZERO:
    assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data not idle");
  AST_STATUS_ACQ:
    assert property (RD && ADDR == FMA_REG_STATUS |=> RDATA[1] == $past(ACQ_RUNNING))
      else $error("status run bit wrong");
  AST_FROZEN_WRITE:
    assert property (p_frozen) else $error("write accepted while running");
  AST_PASS_MIRROR:
    assert property (IMG_VALID && IMG_READY |-> OUT_VALID && OUT_DATA == IMG_DATA)
      else $error("image word not passed");
  AST_READY_NEEDS_OUT:
    assert property (IMG_READY |-> OUT_READY) else $error("image taken while host stalls");
  AST_OUT_HOLD:
    assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA)
      && $stable(OUT_LAST)) else $error("output word dropped while stalled");
  AST_CRC_LAST:
    assert property (s_crc_hdr |=> OUT_VALID && OUT_LAST) else $error("checksum not last");
  AST_LAST_BY_ACTIVATE:
    assert property (IMG_VALID && IMG_READY && IMG_LAST |-> OUT_LAST == !act_q)
      else $error("frame end does not follow activate");
endmodule
bind fma_top fma_monitor u_mon (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .ACQ_RUNNING(ACQ_RUNNING), .IMG_DATA(IMG_DATA),
  .IMG_VALID(IMG_VALID), .IMG_LAST(IMG_LAST), .IMG_READY(IMG_READY), .OUT_DATA(OUT_DATA),
  .OUT_VALID(OUT_VALID), .OUT_LAST(OUT_LAST), .OUT_READY(OUT_READY));

// File: verification/fma_host_model.sv
// Purpose: Host sink for the appender output stream.
// Assumes: A word is taken at an edge with valid and ready high.
// Notes: Stall mode toggles ready so every word may wait.
`timescale 1ns/1ns
module fma_host_model (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [31:0] OUT_DATA,
  input wire logic OUT_VALID,
  input wire logic OUT_LAST,
  input wire logic stall,
  output logic OUT_READY
);
  logic [31:0] words[$]; // Words taken in the current frame.
  int n_last = 0; // Frames seen to their end.
  // A slow host drops ready every other cycle.
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
      OUT_READY <= 1'b0;
    else
      OUT_READY <= stall ? !OUT_READY : 1'b1;
  // Capture accepted words and count frame ends.
  always @(posedge CLK)
    if (RST_B && OUT_VALID && OUT_READY)
    begin
      words.push_back(OUT_DATA);
      n_last += int'(OUT_LAST);
    end
endmodule

// File: verification/tb_fma_top.sv
// Purpose: Self-checking bench for the frame metadata appender.
// Assumes: Host model sinks the output stream.
// Notes: Serial, line and exposure-end inputs are driven only by the closing status test.
`timescale 1ns/1ns
module tb_fma_top
  import fma_pkg::*;
  ;
  logic CLK = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0, ACQ_RUNNING = 1'b0, stall = 1'b0;
  logic IMG_VALID = 1'b0, IMG_LAST = 1'b0, COMPRESSED = 1'b0, EXPOSURE_END = 1'b0;
  logic SER_VALID = 1'b0;
  logic [7:0] ADDR = 8'h00, PIXEL_FORMAT = 8'h00, SEQ_INDEX = 8'h00, SER_DATA = 8'h00;
  logic [31:0] WDATA = 32'h0, IMG_DATA = 32'h0, FRAME_ID = 32'h0, EXPOSURE = 32'h0;
  logic [31:0] BLACK_LEVEL = 32'h0, COMP_RATIO = 32'h0, BITRATE = 32'h0;
  logic [15:0] OFFSET_X = 16'h0, OFFSET_Y = 16'h0, WIDTH = 16'h0, HEIGHT = 16'h0;
  logic [63:0] TIMESTAMP = 64'h0;
  logic [127:0] GAIN_ALL = 128'h0;
  logic [3:0] LINES = 4'h0;
  logic [31:0] RDATA, OUT_DATA;
  logic IMG_READY, OUT_VALID, OUT_LAST, OUT_READY;
  logic [31:0] exq[$]; // Words the host should see.
  logic [31:0] crc_q; // Checksum of the last frame sent.
  int num_errors = 0;
  int n_checks = 0;
  fma_top dut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ACQ_RUNNING(ACQ_RUNNING), .IMG_DATA(IMG_DATA), .IMG_VALID(IMG_VALID),
    .IMG_LAST(IMG_LAST), .IMG_READY(IMG_READY), .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID),
    .OUT_LAST(OUT_LAST), .OUT_READY(OUT_READY), .FRAME_ID(FRAME_ID), .OFFSET_X(OFFSET_X),
    .OFFSET_Y(OFFSET_Y), .WIDTH(WIDTH), .HEIGHT(HEIGHT), .EXPOSURE(EXPOSURE),
    .GAIN_ALL(GAIN_ALL), .BLACK_LEVEL(BLACK_LEVEL), .PIXEL_FORMAT(PIXEL_FORMAT),
    .TIMESTAMP(TIMESTAMP), .SEQ_INDEX(SEQ_INDEX), .EXPOSURE_END(EXPOSURE_END),
    .LINES(LINES), .COMPRESSED(COMPRESSED), .COMP_RATIO(COMP_RATIO), .BITRATE(BITRATE),
    .SER_DATA(SER_DATA), .SER_VALID(SER_VALID));
  fma_host_model host (.CLK(CLK), .RST_B(RST_B), .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID),
    .OUT_LAST(OUT_LAST), .stall(stall), .OUT_READY(OUT_READY));
  // The clock runs free at 250 MHz.
  initial
    forever #2 CLK = ~CLK;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // A write costs two cycles so strobes are never assigned twice at one edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  // Read data is sampled mid-cycle, the only cycle it stands.
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK) v = RDATA;
    @(posedge CLK);
    check(nm, v, e);
  endtask
  function automatic logic [31:0] hdr(input logic [4:0] t, input logic [1:0] l);
    return {FMA_HDR_MARK, 3'h0, t, 14'h0, l};
  endfunction
  // Serial checksum, top bit of each word first, no final inversion.
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] w);
    for (int b = 31; b >= 0; b--)
      c = (c[31] ^ w[b]) ? ({c[30:0], 1'b0} ^ FMA_CRC_POLY) : {c[30:0], 1'b0};
    return c;
  endfunction
  // Sends one frame with context derived from k and compares what the host got.
  task automatic frame(input int n, input logic act, input logic [31:0] k);
    logic r;
    int n0;
    n0 = host.n_last;
    host.words.delete();
    exq.delete();
    crc_q = FMA_CRC_SEED;
    {FRAME_ID, OFFSET_X, OFFSET_Y, WIDTH, HEIGHT, EXPOSURE, BLACK_LEVEL, BITRATE} <= {6{k}};
    GAIN_ALL <= {k + 32'h3, k + 32'h2, k + 32'h1, k};
    TIMESTAMP <= {~k, k};
    {PIXEL_FORMAT, SEQ_INDEX} <= k[15:0];
    COMP_RATIO <= k ^ 32'h0000005A;
    for (int i = 0; i < n; i++)
    begin
      IMG_DATA <= k + 32'(i);
      IMG_VALID <= 1'b1;
      IMG_LAST <= (i == n - 1);
      exq.push_back(k + 32'(i));
      crc_q = crc(crc_q, k + 32'(i));
      r = 1'b0;
      for (int j = 0; j < 100 && !r; j++)
      begin
        @(negedge CLK) r = IMG_READY;
        @(posedge CLK);
      end
      check("img_ready", 32'(r), 32'h1);
      if (!r)
        test_done();
    end
    IMG_VALID <= 1'b0;
    if (act)
    begin
      exq.push_back(hdr(FMA_T_FRAME_ID, 2'h0));
      exq.push_back(k);
      exq.push_back(hdr(FMA_T_GAIN, 2'h0));
      exq.push_back(k + 32'h2);
      exq.push_back(hdr(FMA_T_TIMESTAMP, 2'h1));
      exq.push_back(k);
      exq.push_back(~k);
      exq.push_back(hdr(FMA_T_COMP_RATIO, 2'h0));
      exq.push_back(COMPRESSED ? (k ^ 32'h0000005A) : 32'h0);
      exq.push_back(hdr(FMA_T_CHECKSUM, 2'h0));
      exq.push_back(crc_q);
    end
    for (int j = 0; j < 300 && host.n_last == n0; j++)
      @(posedge CLK);
    check("frame_end", 32'(host.n_last - n0), 32'h1);
    if (host.n_last == n0)
      test_done();
    check("word_count", 32'(host.words.size()), 32'(exq.size()));
    foreach (exq[i])
      check("word", host.words[i], exq[i]);
  endtask
  initial
  begin
    logic [7:0] ra[5];
    logic [31:0] rv[5];
    logic [4:0] en[4];
    ra = '{FMA_REG_ACTIVATE, FMA_REG_TYPE_SELECT, FMA_REG_TYPE_INCLUDE, FMA_REG_GAIN_SELECT,
      8'h20};
    rv = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    en = '{FMA_T_FRAME_ID, FMA_T_GAIN, FMA_T_TIMESTAMP, FMA_T_COMP_RATIO};
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    for (int i = 0; i < 5; i++)
      rc(ra[i], rv[i], "reset_value");
    for (int t = 0; t < 2; t++)
    begin
      wr(FMA_REG_TYPE_SELECT, 32'(t));
      wr(FMA_REG_TYPE_INCLUDE, 32'h0);
      rc(FMA_REG_TYPE_INCLUDE, 32'h1, "always_on");
    end
    $display("test reset_and_fixed done");
    for (int t = 0; t < FMA_NUM_TYPES; t++)
    begin
      wr(FMA_REG_TYPE_SELECT, 32'(t));
      rc(FMA_REG_TYPE_SELECT, 32'(t), "select");
      rc(FMA_REG_TYPE_INCLUDE, 32'(t < 2), "include");
    end
    wr(FMA_REG_TYPE_SELECT, 32'h12);
    rc(FMA_REG_TYPE_SELECT, 32'h11, "select_range");
    for (int i = 0; i < 4; i++)
    begin
      wr(FMA_REG_TYPE_SELECT, 32'(en[i]));
      wr(FMA_REG_TYPE_INCLUDE, 32'h1);
      rc(FMA_REG_TYPE_INCLUDE, 32'h1, "include_set");
    end
    wr(FMA_REG_GAIN_SELECT, 32'h2);
    rc(FMA_REG_GAIN_SELECT, 32'h2, "gain_select");
    $display("test selection done");
    ACQ_RUNNING <= 1'b1;
    rc(FMA_REG_ACTIVATE, 32'h0, "activate");
    wr(FMA_REG_ACTIVATE, 32'h1);
    rc(FMA_REG_ACTIVATE, 32'h0, "activate_frozen");
    wr(FMA_REG_TYPE_SELECT, 32'h3);
    rc(FMA_REG_TYPE_SELECT, 32'h10, "select_frozen");
    rc(FMA_REG_STATUS, 32'h2, "status_running");
    $display("test frozen done");
    frame(3, 1'b0, 32'h00001230);
    ACQ_RUNNING <= 1'b0;
    wr(FMA_REG_ACTIVATE, 32'h1);
    rc(FMA_REG_STATUS, 32'h1, "status_idle");
    ACQ_RUNNING <= 1'b1;
    COMPRESSED <= 1'b1;
    stall <= 1'b1;
    frame(4, 1'b1, 32'h00004560);
    rc(FMA_REG_LAST_CHECKSUM, crc_q, "checksum_reg");
    stall <= 1'b0;
    COMPRESSED <= 1'b0;
    frame(1, 1'b1, 32'h00007890);
    $display("test frames done");
    // Lines settle through the synchroniser, then the exposure end event latches them.
    LINES <= 4'h5;
    repeat (3) @(posedge CLK);
    EXPOSURE_END <= 1'b1;
    @(posedge CLK);
    EXPOSURE_END <= 1'b0;
    // Seventeen bytes overrun the sixteen-byte capture buffer.
    SER_DATA <= 8'hA5;
    SER_VALID <= 1'b1;
    repeat (17) @(posedge CLK);
    SER_VALID <= 1'b0;
    rc(FMA_REG_STATUS, 32'h0000000F, "status_lines_ovf");
    $display("test lines and serial done");
    test_done();
  end
endmodule
